// *** rtl/spi_cfg_pkg.sv ***
// Constants and types shared by the configuration serial port
package spi_cfg_pkg;

    // Frame layout
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned CNT_W      = 5;
    localparam logic [4:0]  CNT_FULL   = 5'h18;
    localparam logic [4:0]  CNT_LAST   = 5'h17;

    // Bank 0 register offsets
    localparam logic [7:0] OFS_PORT_CONTROL_WORD    = 8'h00;
    localparam logic [7:0] OFS_CHAIN_LENGTH_CONFIG  = 8'h01;
    localparam logic [7:0] OFS_BANK_SELECTOR        = 8'h03;
    localparam logic [7:0] OFS_INIT_STEP_FIELD      = 8'h04;
    localparam logic [7:0] OFS_CONTROL_WORD_MIRROR  = 8'h06;

    // Daisy-chain command bytes
    localparam logic [7:0] CMD_READ = 8'hfe;
    localparam logic [7:0] CMD_NOP  = 8'hff;

    // Field positions
    localparam int unsigned POS_SOFT_RESET  = 0;
    localparam int unsigned POS_RD_EN       = 1;
    localparam int unsigned POS_PORT_MODE   = 2;
    localparam int unsigned POS_CHAIN_LO    = 2;
    localparam int unsigned POS_CHAIN_HI    = 6;
    localparam int unsigned POS_BANK_HI     = 7;
    localparam int unsigned POS_INIT_HI     = 3;

    // Reset values
    localparam logic [15:0] RST_PORT_CONTROL_WORD   = 16'h0000;
    localparam logic [4:0]  RST_CHAIN_LENGTH        = 5'h00;
    localparam logic [7:0]  RST_BANK_SELECTOR       = 8'h02;
    localparam logic [3:0]  RST_INIT_STEP           = 4'h0;
    localparam logic [15:0] RST_CONTROL_WORD_MIRROR = 16'h0002;

    // Bank selector codes
    localparam logic [7:0] SEL_BANK0 = 8'h00;
    localparam logic [7:0] SEL_BANK1 = 8'h02;
    localparam logic [7:0] SEL_BANK2 = 8'h10;

    typedef enum logic [3:0] {
        BANK_0    = 4'b0001,
        BANK_1    = 4'b0010,
        BANK_2    = 4'b0100,
        BANK_NONE = 4'b1000
    } bank_e;

endpackage : spi_cfg_pkg

// *** rtl/spi_link_shifter.sv ***
// Serial-clock side of the configuration port: shift chain and reply load
`timescale 1ns/10ps
module spi_link_shifter (
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    input  wire logic [23:0] resp_word,
    input  wire logic        resp_valid,
    output logic             sdo,
    output logic [23:0]      frame_word,
    output logic             frame_full
);

    typedef struct packed {
        logic [23:0] sh;
        logic        full;
    } link_s;

    link_s                             st_reg;
    link_s                             st_next;
    logic [spi_cfg_pkg::CNT_W-1:0]     cnt_reg;

    ////////////////////////////////////////////////////////////////////////
    // Shift path; first edge of a frame loads the pending reply
    always_comb begin
        st_next = st_reg;
        if (cnt_reg == '0) begin
            st_next.sh   = {(resp_valid ? resp_word[22:0] : 23'h000000), sdi};
            st_next.full = 1'b0;
        end else begin
            st_next.sh = {st_reg.sh[22:0], sdi};
            if (cnt_reg == spi_cfg_pkg::CNT_LAST) begin
                st_next.full = 1'b1;
            end
        end
    end

    always_ff @(posedge sclk) begin
        if (!cs_n) begin
            st_reg <= st_next;
        end
    end

    // Bit counter restarts with every chip-select frame
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_reg <= '0;
        end else if (cnt_reg != spi_cfg_pkg::CNT_FULL) begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output, MSB first; delay through the chain is 24 clocks
    always_comb begin
        if (cs_n) begin
            sdo = 1'b0;
        end else if (cnt_reg == '0) begin
            sdo = resp_valid & resp_word[23];
        end else begin
            sdo = st_reg.sh[23];
        end
    end

    // Last 24 bits of the frame form the command word
    assign frame_word = st_reg.sh;
    assign frame_full = st_reg.full;

endmodule : spi_link_shifter

// *** rtl/banked_config_spi_port.sv ***
// Banked configuration register port behind a serial control interface
// Function
// - Registers are 16 bits wide, chosen by an 8-bit address in one of three banks.
// - Bank 0 answers whatever bank is selected; its addresses are unique.
// - Bank selector at 0x03 resets to 2; 0, 2, 16 choose banks 0, 1, 2.
// - In legacy mode with read enable set, only control word writes at 0x00 are taken.
// - Legacy mode with read enable: a frame's address is answered next frame.
// - Clearing read enable ends a read session and re-enables writes.
// - Control bit 2 picks legacy or daisy mode; bit 1 matters only in legacy.
// - Writing control bit 0 as one restores every register default.
// - Read-only mirror at 0x06 copies the control word, default 2.
// - Serial input reaches serial output 24 clocks later while selected.
// - Chain length field, bits 6-2 of 0x01, holds device count minus one.
// - A read command loads address and data; next frame shifts them out.
`timescale 1ns/10ps
module banked_config_spi_port (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             port_legacy_mode,
    output logic             read_enabled,
    output logic [4:0]       chain_length,
    output logic [3:0]       init_step,
    output logic [7:0]       bank_select,
    output logic [3:0]       active_bank
);

    typedef struct packed {
        logic [2:0]  cs_sync;
        logic        port_mode;
        logic        rd_en;
        logic [15:0] mirror;
        logic [4:0]  chain_len;
        logic [7:0]  bank_sel;
        logic [3:0]  init_step;
        logic [23:0] resp_word;
        logic        resp_valid;
    } port_s;

    localparam port_s RESET_ST = '{
        cs_sync:    3'h7,
        port_mode:  spi_cfg_pkg::RST_PORT_CONTROL_WORD[spi_cfg_pkg::POS_PORT_MODE],
        rd_en:      spi_cfg_pkg::RST_PORT_CONTROL_WORD[spi_cfg_pkg::POS_RD_EN],
        mirror:     spi_cfg_pkg::RST_CONTROL_WORD_MIRROR,
        chain_len:  spi_cfg_pkg::RST_CHAIN_LENGTH,
        bank_sel:   spi_cfg_pkg::RST_BANK_SELECTOR,
        init_step:  spi_cfg_pkg::RST_INIT_STEP,
        resp_word:  24'h000000,
        resp_valid: 1'b0
    };

    port_s        st_reg;
    port_s        st_next;
    logic [23:0]  frame_word;
    logic         frame_full;
    logic         frame_end;
    logic [7:0]   f_addr;
    logic [15:0]  f_data;
    logic         do_write;
    logic         do_read;

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Bank selector code to bank
    function automatic spi_cfg_pkg::bank_e bank_of(input logic [7:0] sel);
        unique case (sel)
            spi_cfg_pkg::SEL_BANK0: bank_of = spi_cfg_pkg::BANK_0;
            spi_cfg_pkg::SEL_BANK1: bank_of = spi_cfg_pkg::BANK_1;
            spi_cfg_pkg::SEL_BANK2: bank_of = spi_cfg_pkg::BANK_2;
            default:                bank_of = spi_cfg_pkg::BANK_NONE;
        endcase
    endfunction : bank_of

    // Addresses owned by bank 0
    function automatic logic is_bank0(input logic [7:0] addr);
        is_bank0 = (addr == spi_cfg_pkg::OFS_PORT_CONTROL_WORD)   ||
                   (addr == spi_cfg_pkg::OFS_CHAIN_LENGTH_CONFIG) ||
                   (addr == spi_cfg_pkg::OFS_BANK_SELECTOR)       ||
                   (addr == spi_cfg_pkg::OFS_INIT_STEP_FIELD)     ||
                   (addr == spi_cfg_pkg::OFS_CONTROL_WORD_MIRROR);
    endfunction : is_bank0

    // Read value of an address; banks 1 and 2 live outside this port
    function automatic logic [15:0] read_value(input port_s s, input logic [7:0] addr);
        read_value = 16'h0000;
        if (is_bank0(addr)) begin
            unique case (addr)
                spi_cfg_pkg::OFS_CHAIN_LENGTH_CONFIG:
                    read_value[spi_cfg_pkg::POS_CHAIN_HI:spi_cfg_pkg::POS_CHAIN_LO] = s.chain_len;
                spi_cfg_pkg::OFS_BANK_SELECTOR:
                    read_value[spi_cfg_pkg::POS_BANK_HI:0] = s.bank_sel;
                spi_cfg_pkg::OFS_INIT_STEP_FIELD:
                    read_value[spi_cfg_pkg::POS_INIT_HI:0] = s.init_step;
                spi_cfg_pkg::OFS_CONTROL_WORD_MIRROR:
                    read_value = s.mirror;
                default:
                    read_value = 16'h0000;
            endcase
        end
    endfunction : read_value

    ////////////////////////////////////////////////////////////////////////
    // Serial-clock side

    spi_link_shifter u_link (
        .sclk       (sclk),
        .cs_n       (cs_n),
        .sdi        (sdi),
        .resp_word  (st_reg.resp_word),
        .resp_valid (st_reg.resp_valid),
        .sdo        (sdo),
        .frame_word (frame_word),
        .frame_full (frame_full)
    );

    ////////////////////////////////////////////////////////////////////////
    // Frame decode; word is stable once select has risen

    assign frame_end = st_reg.cs_sync[1] & ~st_reg.cs_sync[2];
    assign f_addr    = frame_word[23:16];
    assign f_data    = frame_word[15:0];

    always_comb begin
        do_write = 1'b0;
        do_read  = 1'b0;
        if (frame_end && frame_full) begin
            if (!st_reg.port_mode) begin
                // Daisy mode ignores read enable
                if (f_addr == spi_cfg_pkg::CMD_READ) begin
                    do_read = 1'b1;
                end else if (f_addr != spi_cfg_pkg::CMD_NOP) begin
                    do_write = 1'b1;
                end
            end else if (st_reg.rd_en) begin
                if (f_addr == spi_cfg_pkg::OFS_PORT_CONTROL_WORD) begin
                    do_write = 1'b1;
                end else begin
                    do_read = 1'b1;
                end
            end else begin
                do_write = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file and reply staging

    always_comb begin
        st_next         = st_reg;
        st_next.cs_sync = {st_reg.cs_sync[1:0], cs_n};
        if (frame_end) begin
            st_next.resp_valid = 1'b0;
        end
        if (do_read) begin
            if (!st_reg.port_mode) begin
                // Read command word carries the address in its low byte
                st_next.resp_word = {frame_word[7:0], read_value(st_reg, frame_word[7:0])};
            end else begin
                st_next.resp_word = {f_addr, read_value(st_reg, f_addr)};
            end
            st_next.resp_valid = 1'b1;
        end
        if (do_write) begin
            unique case (f_addr)
                spi_cfg_pkg::OFS_PORT_CONTROL_WORD: begin
                    if (f_data[spi_cfg_pkg::POS_SOFT_RESET]) begin
                        st_next         = RESET_ST;
                        st_next.cs_sync = {st_reg.cs_sync[1:0], cs_n};
                    end else begin
                        st_next.port_mode = f_data[spi_cfg_pkg::POS_PORT_MODE];
                        st_next.rd_en     = f_data[spi_cfg_pkg::POS_RD_EN];
                        st_next.mirror    = f_data;
                    end
                end
                spi_cfg_pkg::OFS_CHAIN_LENGTH_CONFIG:
                    st_next.chain_len =
                        f_data[spi_cfg_pkg::POS_CHAIN_HI:spi_cfg_pkg::POS_CHAIN_LO];
                spi_cfg_pkg::OFS_BANK_SELECTOR:
                    st_next.bank_sel = f_data[spi_cfg_pkg::POS_BANK_HI:0];
                spi_cfg_pkg::OFS_INIT_STEP_FIELD:
                    st_next.init_step = f_data[spi_cfg_pkg::POS_INIT_HI:0];
                default: begin
                    // Mirror is read-only; bank 1/2 writes belong elsewhere
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= RESET_ST;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign port_legacy_mode = st_reg.port_mode;
    assign read_enabled     = st_reg.port_mode & st_reg.rd_en;
    assign chain_length     = st_reg.chain_len;
    assign init_step        = st_reg.init_step;
    assign bank_select      = st_reg.bank_sel;
    assign active_bank      = bank_of(st_reg.bank_sel);

endmodule : banked_config_spi_port

// *** verif/banked_config_spi_port_checker.sv ***
// Assertions on the configuration port outputs
`timescale 1ns/10ps
module banked_config_spi_port_checker (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       cs_n,
    input wire logic       sdo,
    input wire logic       port_legacy_mode,
    input wire logic       read_enabled,
    input wire logic [4:0] chain_length,
    input wire logic [3:0] init_step,
    input wire logic [7:0] bank_select,
    input wire logic [3:0] active_bank
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////////
    a_bank_decode: assert property (active_bank == (bank_select == 8'h00 ? 4'b0001 :
        bank_select == 8'h02 ? 4'b0010 : bank_select == 8'h10 ? 4'b0100 : 4'b1000))
        else $error("bank decode wrong");
    a_bank_onehot: assert property ($onehot(active_bank))
        else $error("bank select not one-hot");
    a_read_legacy: assert property (read_enabled |-> port_legacy_mode)
        else $error("reads enabled outside legacy mode");
    a_bank_reset: assert property ($fell(sys_rst) |-> bank_select == 8'h02)
        else $error("bank select reset value wrong");
    a_reset_defaults: assert property ($fell(sys_rst) |-> !port_legacy_mode &&
        !read_enabled && chain_length == 5'h00 && init_step == 4'h0)
        else $error("config reset values wrong");
    a_sdo_idle: assert property (cs_n |-> !sdo)
        else $error("serial output active while deselected");
    a_write_blocked: assert property (read_enabled ##1 read_enabled |->
        $stable(bank_select) && $stable(chain_length) && $stable(init_step))
        else $error("register written while reads enabled");
    a_frame_bound: assert property ($changed(bank_select) || $changed(chain_length)
        || $changed(init_step) |-> $past(cs_n, 1) && $past(cs_n, 2))
        else $error("config changed inside a frame");

    c_read_mode: cover property (read_enabled);
    c_bank_two: cover property (active_bank == 4'b0100);
    c_chain_set: cover property ($changed(chain_length));
endmodule : banked_config_spi_port_checker

bind banked_config_spi_port banked_config_spi_port_checker i_chk (
    .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sdo(sdo),
    .port_legacy_mode(port_legacy_mode), .read_enabled(read_enabled),
    .chain_length(chain_length), .init_step(init_step),
    .bank_select(bank_select), .active_bank(active_bank));

// *** verif/spi_ctrl_model.sv ***
// Behavioural serial controller on the far side of the port
`timescale 1ns/10ps
module spi_ctrl_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    // Word sent n times in one frame; rx holds sdo during the last word
    task automatic frame(input int n, input logic [23:0] w, output logic [23:0] rx);
        #3.3;
        cs_n = 1'b0;
        for (int k = 0; k < n * 24; k++) begin
            sdi = w[23 - (k % 24)];
            #7.5;
            if (k >= (n - 1) * 24) rx[23 - (k % 24)] = sdo;
            sclk = 1'b1;
            #7.5;
            sclk = 1'b0;
        end
        #7.5;
        cs_n = 1'b1;
        sdi  = ~sdi;
        #100;
    endtask : frame
endmodule : spi_ctrl_model

// *** verif/banked_config_spi_port_tb_top.sv ***
// Self-checking bench for the banked configuration serial port
`timescale 1ns/10ps
module banked_config_spi_port_tb_top;
    logic        clk;
    logic        sys_rst;
    logic        ce;
    logic        sclk;
    logic        cs_n;
    logic        sdi;
    logic        sdo;
    logic        port_legacy_mode;
    logic        read_enabled;
    logic [4:0]  chain_length;
    logic [3:0]  init_step;
    logic [7:0]  bank_select;
    logic [3:0]  active_bank;
    logic [23:0] rx;
    int          errors;
    int          num_checks;

    banked_config_spi_port i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .port_legacy_mode(port_legacy_mode),
        .read_enabled(read_enabled), .chain_length(chain_length), .init_step(init_step),
        .bank_select(bank_select), .active_bank(active_bank));
    spi_ctrl_model i_ctrl (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Bank, decode, chain, init, legacy, read enable
    task automatic cfg(input logic [22:0] e);
        chk("config", {1'b0, e}, {1'b0, bank_select, active_bank, chain_length, init_step,
            port_legacy_mode, read_enabled});
    endtask : cfg

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_ctrl.frame(1, {a, d}, rx);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        i_ctrl.frame(1, {8'hfe, 8'h00, a}, rx);
        i_ctrl.frame(1, 24'hffffff, rx);
        chk("daisy_reply", {a, exp}, rx);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        cfg({8'h02, 4'b0010, 5'h00, 4'h0, 2'b00});
        rd(8'h06, 16'h0002);
        rd(8'h03, 16'h0002);
    endtask : t_reset_values

    task automatic t_bank_codes();
        logic [7:0] code [4] = '{8'h00, 8'h10, 8'h05, 8'h02};
        logic [3:0] hot [4] = '{4'b0001, 4'b0100, 4'b1000, 4'b0010};
        for (int i = 0; i < 4; i++) begin
            wr(8'h03, {8'h00, code[i]});
            chk("active_bank", {code[i], 12'h000, hot[i]}, {bank_select, 12'h000, active_bank});
            rd(8'h03, {8'h00, code[i]});
        end
        wr(8'h06, 16'h00ff);
        rd(8'h06, 16'h0002);
    endtask : t_bank_codes

    // Init key and bank 1 writes land outside this port; bank 0 must be untouched
    task automatic t_init_sequence();
        wr(8'h03, 16'h0002);
        wr(8'h33, 16'h0030);
        wr(8'h04, 16'h000b);
        chk("init_step", 24'h00000b, 24'(init_step));
        wr(8'h04, 16'h0000);
        // Settling wait left out: nothing in this port times it
        wr(8'h03, 16'h0002);
        wr(8'h33, 16'h0000);
        wr(8'h0d, 16'h2002);
        wr(8'h33, 16'h2040);
        rd(8'h33, 16'h0000);
        cfg({8'h02, 4'b0010, 5'h00, 4'h0, 2'b00});
    endtask : t_init_sequence

    task automatic t_daisy_chain();
        i_ctrl.frame(2, {8'h01, 16'h0004}, rx);
        chk("passthrough", {8'h01, 16'h0004}, rx);
        chk("chain_length", 24'h000001, 24'(chain_length));
        rd(8'h01, 16'h0004);
        wr(8'h01, 16'h007c);
        chk("chain_length", 24'h00001f, 24'(chain_length));
        wr(8'h04, 16'h000b);
        chk("init_step", 24'h00000b, 24'(init_step));
        wr(8'h04, 16'h0000);
        chk("init_step", 24'h000000, 24'(init_step));
    endtask : t_daisy_chain

    task automatic t_legacy_read();
        wr(8'h00, 16'h0006);
        chk("mode", 24'h000003, 24'({port_legacy_mode, read_enabled}));
        wr(8'h03, 16'h1234);
        wr(8'h06, 16'h0000);
        chk("legacy_reply", {8'h03, 16'h0002}, rx);
        chk("bank_select", 24'h000002, 24'(bank_select));
        wr(8'h00, 16'h0004);
        chk("mirror_reply", {8'h06, 16'h0006}, rx);
        chk("mode", 24'h000002, 24'({port_legacy_mode, read_enabled}));
        wr(8'h03, 16'h0010);
        chk("bank_select", 24'h000010, 24'(bank_select));
        wr(8'h00, 16'h0002);
        chk("mode", 24'h000000, 24'({port_legacy_mode, read_enabled}));
    endtask : t_legacy_read

    task automatic t_soft_reset();
        wr(8'h01, 16'h0010);
        wr(8'h04, 16'h0005);
        chk("chain_length", 24'h000004, 24'(chain_length));
        wr(8'h00, 16'h0001);
        cfg({8'h02, 4'b0010, 5'h00, 4'h0, 2'b00});
        rd(8'h06, 16'h0002);
        wr(8'h03, 16'h0000);
        // Frame sent while the clock enable is low is lost
        @(posedge clk) ce <= 1'b0;
        wr(8'h04, 16'h000b);
        @(posedge clk) ce <= 1'b1;
        repeat (4) @(posedge clk);
        chk("frozen_init", 24'h000000, 24'(init_step));
        @(posedge clk) sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        cfg({8'h02, 4'b0010, 5'h00, 4'h0, 2'b00});
    endtask : t_soft_reset

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        errors     = 0;
        num_checks = 0;
        sys_rst    = 1'b1;
        ce         = 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset_values();
        t_bank_codes();
        t_init_sequence();
        t_daisy_chain();
        t_legacy_read();
        t_soft_reset();
        stop_test();
    end

    initial begin
        repeat (50000) @(posedge clk);
        errors++;
        stop_test();
    end
endmodule : banked_config_spi_port_tb_top
